// [rtl/link_control_register.sv]
// link control register with transmitter/receiver gating
// Notes on behaviour
// - All control bits clear at power up unless stated otherwise.
// - Bit 00 requests a device reset from software.
// - Page select picks lower or upper 256 bytes of 512 byte data RAM.
// - Busy policy one forces busy acknowledge on every incoming packet.
// - Transmit enable low stops arbitration and packet sending.
// - Transmit enable powers up set.
// - Receive enable low makes receiver accept no packets.
// - Receive enable powers up set and survives serial-bus reset.
// - Writing transmit reset pulses a synchronous transmitter reset, self clearing.
// - Writing receive reset pulses a synchronous receiver reset, self clearing.
// - Long hold enable extends hold after bus grant to 10 cycles.
// - Clear self-ID error is write-only and clears after one cycle.
// - Power-switch pin follows power-on bit; firmware sets it.
// - Bit 00 is the msb of the quadlet, bit 31 the lsb.
`timescale 1ns/100ps
module link_control_register (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [link_ctrl_pkg::ADDR_W-1:0] ADDR,
  input wire logic [link_ctrl_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [link_ctrl_pkg::DATA_W-1:0] RDATA,
  input wire logic BUS_RESET,
  input wire logic BUS_GRANT,
  input wire logic TX_ARB_REQ,
  input wire logic RX_PKT_VALID,
  input wire logic RX_NEED_BUSY,
  input wire logic [7:0] CPU_DATA_ADDR,
  output logic SOFT_RESET_REQUEST,
  output logic [8:0] DATA_RAM_ADDR,
  output logic TX_ARB_GO,
  output logic TX_GRANT_HOLD,
  output logic RX_ACCEPT,
  output logic RX_SEND_BUSY,
  output logic TRANSMITTER_RESET,
  output logic RECEIVER_RESET,
  output logic CLEAR_SELFID_ERROR,
  output logic POWER_SWITCH_OUTPUT
);
  import link_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire sel = (ADDR == LINK_CONTROL_OFFSET);
  wire wr_ctl = WR && sel;
  wire rd_ctl = RD && sel;

  ////////////////////////////////////////////////////////////////////////
  // stored fields
  logic soft_reset_q;
  logic page_q;
  logic busy_q;
  logic tx_en_q;
  logic rx_en_q;
  logic long_hold_q;
  logic power_q;
  logic [31:0] rdata_q;

  // power-up values; enables come up set, the rest clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      soft_reset_q <= 1'b0;
      page_q <= 1'b0;
      busy_q <= 1'b0;
      tx_en_q <= 1'b1;
      rx_en_q <= 1'b1;
      long_hold_q <= 1'b0;
      power_q <= 1'b0;
    end else if (wr_ctl) begin
      // writes land at msb-first positions; reserved bits dropped
      soft_reset_q <= WDATA[BIT_SOFT_RESET];
      page_q <= WDATA[BIT_PAGE_SELECT];
      busy_q <= WDATA[BIT_BUSY_POLICY];
      tx_en_q <= WDATA[BIT_TX_ENABLE];
      rx_en_q <= WDATA[BIT_RX_ENABLE];
      long_hold_q <= WDATA[BIT_LONG_HOLD];
      power_q <= WDATA[BIT_POWER_SWITCH];
    end
  end
  // BUS_RESET deliberately touches no field, so receive enable survives it

  ////////////////////////////////////////////////////////////////////////
  // self-clearing strobes
  self_clear_pulse u_tx_rst (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .set(wr_ctl && WDATA[BIT_TX_RESET]),
    .pulse(TRANSMITTER_RESET)
  );
  self_clear_pulse u_rx_rst (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .set(wr_ctl && WDATA[BIT_RX_RESET]),
    .pulse(RECEIVER_RESET)
  );
  self_clear_pulse u_clr_sid (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .set(wr_ctl && WDATA[BIT_CLR_SELFID]),
    .pulse(CLEAR_SELFID_ERROR)
  );

  ////////////////////////////////////////////////////////////////////////
  // grant hold
  logic holding;
  grant_hold_timer u_hold (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .grant(BUS_GRANT),
    .long_hold(long_hold_q),
    .holding(holding)
  );

  ////////////////////////////////////////////////////////////////////////
  // datapath gating; a reset pulse also blocks arbitration or packet accept for that cycle, but not grant hold
  assign TX_ARB_GO = TX_ARB_REQ && tx_en_q && !TRANSMITTER_RESET;
  assign TX_GRANT_HOLD = holding && tx_en_q;
  assign RX_ACCEPT = RX_PKT_VALID && rx_en_q && !RECEIVER_RESET;
  assign RX_SEND_BUSY = RX_ACCEPT && (busy_q || RX_NEED_BUSY);
  assign DATA_RAM_ADDR = {page_q, CPU_DATA_ADDR};
  assign SOFT_RESET_REQUEST = soft_reset_q;
  assign POWER_SWITCH_OUTPUT = power_q;

  ////////////////////////////////////////////////////////////////////////
  // read image: write-only and self-clearing bits read zero
  wire [31:0] image = {soft_reset_q, 2'h0, page_q, busy_q, tx_en_q, rx_en_q,
    3'h0, 2'h0, 2'h0, long_hold_q, 8'h00, 1'b0, 3'h0, power_q, 4'h0};

  // unmapped reads return zero
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_ctl ? image : 32'h0000_0000;
    end
  end
  assign RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (RDATA & ~RW_MASK) == 32'h0000_0000)
    else $error("reserved bit read nonzero");
  a_tx_gate_off: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !tx_en_q |-> !TX_ARB_GO && !TX_GRANT_HOLD)
    else $error("transmitter active while disabled");
  a_rx_gate_off: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !rx_en_q |-> !RX_ACCEPT && !RX_SEND_BUSY)
    else $error("receiver accepted while disabled");
  a_busy_forced: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    busy_q && RX_ACCEPT |-> RX_SEND_BUSY)
    else $error("busy policy not forcing busy");
  a_rx_keep_bus: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    BUS_RESET && !wr_ctl |=> rx_en_q == $past(rx_en_q))
    else $error("receive enable changed on bus reset");
  a_rd_data_img: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rd_ctl && !wr_ctl |=> RDATA[BIT_TX_ENABLE] == tx_en_q)
    else $error("read data misplaced transmit enable");
  a_power_follows: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> POWER_SWITCH_OUTPUT == $past(WDATA[BIT_POWER_SWITCH]))
    else $error("power switch pin does not follow bit");
  a_page_addr: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> DATA_RAM_ADDR[8] == $past(WDATA[BIT_PAGE_SELECT]))
    else $error("page select not applied");
  a_txrst_clear: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl && WDATA[BIT_TX_RESET] ##1 !(wr_ctl && WDATA[BIT_TX_RESET])
    |-> TRANSMITTER_RESET ##1 !TRANSMITTER_RESET)
    else $error("transmitter reset not self clearing");
  a_soft_reset: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> SOFT_RESET_REQUEST == $past(WDATA[BIT_SOFT_RESET]))
    else $error("soft reset bit not applied");

  ////////////////////////////////////////////////////////////////////////
  // reset strobes: each one is a single cycle; transmitter reset blocks arbitration, receiver reset blocks packet accept

  // receiver reset must drop again unless rewritten
  a_rxrst_clear: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl && WDATA[BIT_RX_RESET] ##1 !(wr_ctl && WDATA[BIT_RX_RESET])
    |-> RECEIVER_RESET ##1 !RECEIVER_RESET)
    else $error("receiver reset not self clearing");

  // clear self-ID error lasts exactly one link clock cycle
  a_clrsid_clear: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl && WDATA[BIT_CLR_SELFID] ##1 !(wr_ctl && WDATA[BIT_CLR_SELFID])
    |-> CLEAR_SELFID_ERROR ##1 !CLEAR_SELFID_ERROR)
    else $error("clear self-ID error not self clearing");

  // a transmitter reset pulse never lets arbitration through
  a_txrst_block: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    TRANSMITTER_RESET |-> !TX_ARB_GO)
    else $error("arbitration during transmitter reset");

  // a receiver reset pulse never lets a packet in
  a_rxrst_block: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RECEIVER_RESET |-> !RX_ACCEPT)
    else $error("packet accepted during receiver reset");

  // strobes only ever follow a write to the register
  a_txrst_cause: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    TRANSMITTER_RESET |-> $past(wr_ctl))
    else $error("transmitter reset without a write");

  a_rxrst_cause: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RECEIVER_RESET |-> $past(wr_ctl))
    else $error("receiver reset without a write");

  a_clrsid_cause: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    CLEAR_SELFID_ERROR |-> $past(wr_ctl))
    else $error("clear self-ID error without a write");

  ////////////////////////////////////////////////////////////////////////
  // gating in the enabled direction: an enable must not block more than it should

  // enabled transmitter passes a request straight through
  a_tx_gate_on: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    tx_en_q && TX_ARB_REQ && !TRANSMITTER_RESET |-> TX_ARB_GO)
    else $error("enabled transmitter blocked");

  // enabled receiver takes a valid packet
  a_rx_gate_on: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rx_en_q && RX_PKT_VALID && !RECEIVER_RESET |-> RX_ACCEPT)
    else $error("enabled receiver blocked");

  // normal protocol sends busy only when the receiver needs it
  a_busy_normal: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !busy_q && RX_ACCEPT && !RX_NEED_BUSY |-> !RX_SEND_BUSY)
    else $error("busy sent without need");

  a_busy_needed: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RX_ACCEPT && RX_NEED_BUSY |-> RX_SEND_BUSY)
    else $error("needed busy not sent");

  // busy is an answer, so there must be a packet behind it
  a_busy_accepted: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RX_SEND_BUSY |-> RX_ACCEPT)
    else $error("busy sent for refused packet");

  // grant hold can only show while the timer runs
  a_hold_gated: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    TX_GRANT_HOLD |-> holding)
    else $error("grant hold without timer");

  ////////////////////////////////////////////////////////////////////////
  // field storage: writes land, and nothing else moves a field

  a_transmitter_enable_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> tx_en_q == $past(WDATA[BIT_TX_ENABLE]))
    else $error("transmit enable not applied");

  a_receiver_enable_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> rx_en_q == $past(WDATA[BIT_RX_ENABLE]))
    else $error("receive enable not applied");

  a_busy_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> busy_q == $past(WDATA[BIT_BUSY_POLICY]))
    else $error("busy policy not applied");

  a_long_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> long_hold_q == $past(WDATA[BIT_LONG_HOLD]))
    else $error("long hold enable not applied");

  // without a write transmit enable, receive enable and busy policy keep their values
  a_fields_stable: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !wr_ctl |=> $stable(tx_en_q) && $stable(rx_en_q) && $stable(busy_q))
    else $error("control field moved without a write");

  a_power_stable: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !wr_ctl |=> $stable(POWER_SWITCH_OUTPUT))
    else $error("power switch pin moved without a write");

  // the low address bits always come from the processor
  a_page_low: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    DATA_RAM_ADDR[7:0] == CPU_DATA_ADDR)
    else $error("data address low bits altered");

  ////////////////////////////////////////////////////////////////////////
  // read port

  // an unmapped read returns zero
  a_unmapped_zero: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RD && !sel |=> RDATA == 32'h0000_0000)
    else $error("unmapped read nonzero");

  // read data stand only in the cycle after a read
  a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !rd_ctl |=> RDATA == 32'h0000_0000)
    else $error("read data outside read cycle");

  // write-only and self-clearing bits never show in the image
  a_wo_bits_zero: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rd_ctl |=> !RDATA[BIT_CLR_SELFID] && !RDATA[BIT_TX_RESET]
    && !RDATA[BIT_RX_RESET])
    else $error("write-only bit read back");
endmodule

// [rtl/link_ctrl_pkg.sv]
// constants for the link control register bank
package link_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] LINK_CONTROL_OFFSET = 8'h08;
  // bit numbering: bit 00 is the msb, so field k sits at vector index 31-k
  localparam int BIT_SOFT_RESET = 31 - 0;
  localparam int BIT_PAGE_SELECT = 31 - 3;
  localparam int BIT_BUSY_POLICY = 31 - 4;
  localparam int BIT_TX_ENABLE = 31 - 5;
  localparam int BIT_RX_ENABLE = 31 - 6;
  localparam int BIT_TX_RESET = 31 - 10;
  localparam int BIT_RX_RESET = 31 - 11;
  localparam int BIT_LONG_HOLD = 31 - 14;
  localparam int BIT_CLR_SELFID = 31 - 23;
  localparam int BIT_POWER_SWITCH = 31 - 27;
  // hold after a bus grant, in link clock cycles
  localparam logic [3:0] HOLD_SHORT_CYCLES = 4'h1;
  localparam logic [3:0] HOLD_LONG_CYCLES = 4'hA;
  // self-clearing pulse length, in cycles
  localparam logic [1:0] PULSE_CYCLES = 2'h1;
  // writable read-back mask and power-up value
  // the soft reset bit is stored and reads back, so it belongs in the mask
  localparam logic [31:0] RW_MASK = 32'h9E02_0010;
  localparam logic [31:0] RESET_VALUE = 32'h0600_0000;
endpackage

// [rtl/self_clear_pulse.sv]
// one-cycle self-clearing control bit
`timescale 1ns/100ps
module self_clear_pulse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  output logic pulse
);
  import link_ctrl_pkg::*;
  logic pulse_q;
  // bit clears itself one cycle after being written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= set;
    end
  end
  assign pulse = pulse_q;
  a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    set ##1 !set |-> pulse ##1 !pulse)
    else $error("self clear pulse did not last one cycle");
endmodule

// [rtl/grant_hold_timer.sv]
// bus grant hold counter
`timescale 1ns/100ps
module grant_hold_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic grant,
  input wire logic long_hold,
  output logic holding
);
  import link_ctrl_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire [3:0] hold_len = long_hold ? HOLD_LONG_CYCLES : HOLD_SHORT_CYCLES;
  // load on grant, count down to zero
  assign cnt_d = grant ? hold_len : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign holding = (cnt_q != 4'h0);

  // check helpers: length of the current hold run and the mode taken at its grant
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic long_seen_q;
  assign run_d = grant ? 4'h0 : (holding ? (run_q != 4'hF ? run_q + 4'h1 : run_q) : 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 4'h0;
      long_seen_q <= 1'b0;
    end else begin
      run_q <= run_d;
      long_seen_q <= grant ? long_hold : long_seen_q;
    end
  end
  a_long_hold_len: assert property (@(posedge clk) disable iff (!rst_n)
    !holding && $past(holding) && long_seen_q |-> run_q == HOLD_LONG_CYCLES)
    else $error("long grant hold not ten cycles");
  a_short_hold_len: assert property (@(posedge clk) disable iff (!rst_n)
    grant && !long_hold ##1 !grant |-> holding ##1 !holding)
    else $error("short grant hold not one cycle");
endmodule

// [sim/link_control_register_test.sv]
// self-checking testbench for the link control register bank
`timescale 1ns/100ps
module link_control_register_test;
  import link_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus_reset = 1'b0;
  logic grant = 1'b0;
  logic tx_req = 1'b1;
  logic rx_valid = 1'b1;
  logic need_busy = 1'b0;
  logic [31:0] rdata;
  logic [8:0] ram_addr;
  logic soft_rst, arb_go, hold, rx_acc, rx_busy, tx_rst, rx_rst, clr_err, pwr;
  int num_errors = 0;
  int checked = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset and design
  always #5 clk = ~clk;
  link_control_register link_control_register_inst (.REF_CLK(clk), .RESETN(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUS_RESET(bus_reset), .BUS_GRANT(grant),
    .TX_ARB_REQ(tx_req), .RX_PKT_VALID(rx_valid), .RX_NEED_BUSY(need_busy),
    .CPU_DATA_ADDR(8'hA5),
    .SOFT_RESET_REQUEST(soft_rst), .DATA_RAM_ADDR(ram_addr), .TX_ARB_GO(arb_go),
    .TX_GRANT_HOLD(hold), .RX_ACCEPT(rx_acc), .RX_SEND_BUSY(rx_busy),
    .TRANSMITTER_RESET(tx_rst), .RECEIVER_RESET(rx_rst), .CLEAR_SELFID_ERROR(clr_err),
    .POWER_SWITCH_OUTPUT(pwr));
  ////////////////////////////////////////////////////////////////////////////////
  // shared compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // returns just after the edge that took the write, so effects can be seen
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic gating;
    chk({arb_go, rx_acc, rx_busy}, 32'h6);
    wr_reg(8'h08, 32'h0800_0000);
    chk({arb_go, rx_acc}, 32'h0);
    wr_reg(8'h08, 32'h0E00_0000);
    chk(rx_busy, 32'h1);
    wr_reg(8'h08, 32'h0600_0000);
    chk({arb_go, rx_busy}, 32'h2);
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0600_0000);
  endtask
  // datapath requests, normal busy and the blocking reset strobes
  task automatic datapath;
    @(posedge clk);
    tx_req <= 1'b0;
    rx_valid <= 1'b0;
    @(posedge clk);
    #1 chk({arb_go, rx_acc, rx_busy}, 32'h0);
    @(posedge clk);
    tx_req <= 1'b1;
    rx_valid <= 1'b1;
    need_busy <= 1'b1;
    @(posedge clk);
    #1 chk(rx_busy, 32'h1);
    wr_reg(8'h08, 32'h0630_0000);
    chk({arb_go, rx_acc, tx_rst, rx_rst}, 32'h3);
    @(posedge clk);
    #1 chk({arb_go, rx_acc, rx_busy}, 32'h7);
    @(posedge clk);
    need_busy <= 1'b0;
  endtask
  task automatic fields;
    wr_reg(8'h08, 32'hFFFF_FFFF);
    chk({tx_rst, rx_rst, clr_err}, 32'h7);
    chk({soft_rst, pwr, ram_addr}, 32'h7A5);
    @(posedge clk);
    #1 chk({tx_rst, rx_rst, clr_err}, 32'h0);
    // the soft reset bit is masked: its read-back is a designer choice
    rd_chk(8'h08, 32'h7FFF_FFFF, 32'h1E02_0010);
    wr_reg(8'h0C, 32'h0000_0000);
    rd_chk(8'h08, 32'h7FFF_FFFF, 32'h1E02_0010);
    rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr_reg(8'h08, 32'h0602_0000);
    chk({soft_rst, pwr, ram_addr}, 32'h0A5);
  endtask
  // counts hold cycles after one grant pulse
  task automatic grant_count(input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    grant <= 1'b1;
    @(posedge clk);
    grant <= 1'b0;
    #1 n += hold;
    repeat (13) begin
      @(posedge clk);
      #1 n += hold;
    end
    chk(n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic complete_run;
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 90 cycles the scenarios need
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0600_0000);
    chk({soft_rst, pwr, tx_rst, rx_rst, clr_err, ram_addr}, 32'h0A5);
    gating();
    datapath();
    fields();
    grant_count(32'd10);
    wr_reg(8'h08, 32'h0600_0000);
    grant_count(32'd1);
    wr_reg(8'h08, 32'h0002_0000);
    grant_count(32'd0);
    complete_run();
  end
endmodule
